// *** design/ccr_pkg.sv ***
// Purpose: Constants for the C-channel control and diagnostics register bank.
// Assumes: Bit 0 of a C-channel byte is its first bit, stored at index 0.
// Notes: Shared by the register bank and the tied-input detector.
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register select in bits 1:0 of each C-channel byte
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  // Bit 0 low and bit 1 high select the diagnostics register
  localparam logic [1:0] SEL_DIAG = 2'h2;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_RETAIN = 2;
  localparam int CTL_RATE = 3;
  localparam int CTL_INBEARER = 4;
  localparam int CTL_PSHAPE = 5;
  localparam int CTL_FAST = 6;
  localparam int CTL_TX_HOUSEKEEPING_BIT = 7;

  // ----------------------------------------------------------------
  // Diagnostics register fields
  // ----------------------------------------------------------------
  localparam int DIAG_LOOP_LO = 2;
  localparam int DIAG_UNFRAMED = 4;
  localparam int DIAG_POLY = 5;
  localparam int DIAG_LINE_OFF = 6;
  localparam int DIAG_UNUSED = 7;

  // ----------------------------------------------------------------
  // Default-mode shortcut and register values
  // ----------------------------------------------------------------
  localparam logic [3:0] DEFAULT_KEY = 4'hf;
  localparam int DEFAULT_SEL_BIT = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_DEFAULT_LOW = 8'h00;
  localparam logic [7:0] CTL_DEFAULT_HIGH = 8'h08;
  localparam logic [7:0] DIAG_DEFAULT = 8'h02;
  localparam logic [7:0] DIAG_CLEARED = 8'h02;

  // ----------------------------------------------------------------
  // D-channel carriage masks
  // ----------------------------------------------------------------
  localparam logic [7:0] DMASK_LOW = 8'h01;
  localparam logic [7:0] DMASK_HIGH = 8'h03;
  localparam logic [7:0] DMASK_FULL = 8'hff;

  // ----------------------------------------------------------------
  // Echo canceller step size, as a right shift of the update term
  // ----------------------------------------------------------------
  localparam logic [3:0] ADAPT_SHIFT_FAST = 4'h2;
  localparam logic [3:0] ADAPT_SHIFT_NORMAL = 4'h6;

  // ----------------------------------------------------------------
  // Tied control input: whole frames of constant level before use
  // ----------------------------------------------------------------
  localparam logic [2:0] TIE_FRAMES = 3'h2;

  // Loopback path codes
  typedef enum logic [1:0] {
    CCR_LOOP_OFF = 2'b00,
    CCR_LOOP_DATA = 2'b01,
    CCR_LOOP_LINE = 2'b10,
    CCR_LOOP_OTHER = 2'b11
  } ccr_loop_e;

endpackage : ccr_pkg

// *** design/ccr_tie_detect.sv ***
// Purpose: Detects a control serial input held at one level for whole frames.
// Assumes: The pin is asynchronous; the frame pulse is on clk_sys_i.
// Notes: Any accepted change drops the tied indication at once.
`timescale 1ns/1ps
`default_nettype none
module ccr_tie_detect (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic pin_i,
  input wire logic frame_pulse_i,
  output logic tied_o,
  output logic tied_level_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic moved_r;
  logic [2:0] frames_r;

  // ----------------------------------------------------------------
  // Three-flop synchroniser and accepted level
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  // Notes any accepted change within the current frame; a change wins over the pulse
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      moved_r <= 1'b0;
    end else if (s2_r == s3_r && s3_r != level_r) begin
      moved_r <= 1'b1;
    end else if (frame_pulse_i) begin
      moved_r <= 1'b0;
    end
  end

  // Counts quiet frames, saturating at the threshold
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      frames_r <= 3'h0;
    end else if (s2_r == s3_r && s3_r != level_r) begin
      frames_r <= 3'h0;
    end else if (frame_pulse_i) begin
      if (moved_r) begin
        frames_r <= 3'h0;
      end else if (frames_r != ccr_pkg::TIE_FRAMES) begin
        frames_r <= frames_r + 3'h1;
      end
    end
  end

  assign tied_o = (frames_r == ccr_pkg::TIE_FRAMES);
  assign tied_level_o = level_r;

endmodule : ccr_tie_detect
`default_nettype wire

// *** design/ccr_regs.sv ***
// Purpose: Write-only control and diagnostics registers fed by C-channel bytes.
// Assumes: The serial port delivers each received C-channel byte as one strobe.
// Notes: Bytes wait in staging and take effect at the next frame pulse.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE_01 - Byte bits 1:0 equal 00 write control; 01 write diagnostics.
// RULE_02 - Retain bit 0 clears diagnostics at each frame pulse; 1 keeps them.
// RULE_03 - Controller rewrites diagnostics each frame to keep features alive.
// RULE_04 - In-bearer bit carries all eight D bits in the first bearer slot.
// RULE_05 - Rate bit 0 selects 80 kbit/s, 1 selects 160 kbit/s.
// RULE_06 - Fast-converge bit 1 makes the echo canceller adapt faster.
// RULE_07 - Fast-converge bit 0 keeps the ordinary adaptation rate.
// RULE_08 - At 160 kbit/s controller holds fast-converge for 240 frames.
// RULE_09 - At 80 kbit/s controller holds fast-converge for 480 frames.
// RULE_10 - Bits 7:4 all ones select a default mode chosen by bit 3.
// RULE_11 - Default mode one: control 00, diagnostics all features off.
// RULE_12 - Default mode two: control high rate only, diagnostics off.
// RULE_13 - Dual port with control input tied low gives default mode one.
// RULE_14 - Dual port with control input tied high gives default mode two.
// RULE_15 - Diagnostics bits 3:2 pick loopback: off, data, line, other.
// RULE_16 - Poly-exchange bit swaps scrambler and descrambler polynomials.
// RULE_17 - Line-out-disable bit holds the line output at bias level.
// RULE_18 - Controller writes diagnostics bit 7 as zero.
module ccr_regs (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic frame_pulse_i,
  input wire logic [7:0] cbyte_i,
  input wire logic cbyte_valid_i,
  input wire logic dual_port_mode_i,
  input wire logic control_serial_input_i,
  output logic line_rate_select_o,
  output logic diag_reset_retain_o,
  output logic signalling_in_bearer_o,
  output logic pulse_shaping_enable_o,
  output logic fast_converge_o,
  output logic tx_housekeeping_bit_o,
  output logic [7:0] dchan_carry_mask_o,
  output logic [3:0] adapt_shift_o,
  output logic [1:0] loopback_mode_o,
  output logic loop_data_o,
  output logic loop_line_o,
  output logic loop_other_o,
  output logic forced_unframed_o,
  output logic poly_exchange_o,
  output logic scrambler_poly_alt_o,
  output logic descrambler_poly_alt_o,
  output logic line_out_disable_o,
  output logic default_mode_o
);

  logic [7:0] ctl_r;
  logic [7:0] diag_r;
  logic [7:0] ctl_stage_r;
  logic [7:0] diag_stage_r;
  logic ctl_pend_r;
  logic diag_pend_r;
  logic dflt_pend_r;
  logic dflt_high_r;
  logic default_r;
  logic dp_s1_r;
  logic dp_s2_r;
  logic dp_s3_r;
  logic dual_r;
  logic tied;
  logic tied_level;
  logic tie_default;
  logic [1:0] sel;
  logic is_default_key;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Control image for a default mode
  function automatic logic [7:0] default_ctl(input logic high);
    default_ctl = high ? ccr_pkg::CTL_DEFAULT_HIGH : ccr_pkg::CTL_DEFAULT_LOW;
  endfunction : default_ctl

  // Bits 7:4 all ones mark the default-mode shortcut
  function automatic logic key_match(input logic [7:0] b);
    key_match = (b[7:4] == ccr_pkg::DEFAULT_KEY);
  endfunction : key_match

  assign sel = cbyte_i[1:0];
  assign is_default_key = key_match(cbyte_i);

  // ----------------------------------------------------------------
  // Dual-port strap and tied control input
  // ----------------------------------------------------------------

  // Three-flop synchroniser for the mode strap
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dp_s1_r <= 1'b0;
      dp_s2_r <= 1'b0;
      dp_s3_r <= 1'b0;
      dual_r <= 1'b0;
    end else begin
      dp_s1_r <= dual_port_mode_i;
      dp_s2_r <= dp_s1_r;
      dp_s3_r <= dp_s2_r;
      if (dp_s2_r == dp_s3_r) begin
        dual_r <= dp_s3_r;
      end
    end
  end

  ccr_tie_detect u_tie (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .pin_i(control_serial_input_i),
    .frame_pulse_i(frame_pulse_i),
    .tied_o(tied),
    .tied_level_o(tied_level)
  );

  // Tied low or high forces the matching default
  assign tie_default = dual_r && tied; // RULE_13 RULE_14

  // ----------------------------------------------------------------
  // Staging of received bytes until the frame pulse
  // ----------------------------------------------------------------

  // Routes each byte by its select bits; other patterns are dropped
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctl_pend_r <= 1'b0;
      diag_pend_r <= 1'b0;
      dflt_pend_r <= 1'b0;
    end else begin
      // The pulse empties staging; a byte in that cycle waits for the next pulse
      if (frame_pulse_i) begin
        ctl_pend_r <= 1'b0;
        diag_pend_r <= 1'b0;
        dflt_pend_r <= 1'b0;
      end
      if (cbyte_valid_i) begin
        if ((sel == ccr_pkg::SEL_CONTROL || sel == ccr_pkg::SEL_DIAG) && is_default_key) begin
          dflt_pend_r <= 1'b1; // RULE_10
        end else if (sel == ccr_pkg::SEL_CONTROL) begin
          ctl_pend_r <= 1'b1; // RULE_01
        end else if (sel == ccr_pkg::SEL_DIAG) begin
          diag_pend_r <= 1'b1; // RULE_01
        end
      end
    end
  end

  // Holds the last byte of each kind seen this frame
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctl_stage_r <= ccr_pkg::CTL_RESET;
      diag_stage_r <= ccr_pkg::DIAG_CLEARED;
      dflt_high_r <= 1'b0;
    end else if (cbyte_valid_i) begin
      if (is_default_key && (sel == ccr_pkg::SEL_CONTROL || sel == ccr_pkg::SEL_DIAG)) begin
        dflt_high_r <= cbyte_i[ccr_pkg::DEFAULT_SEL_BIT]; // RULE_10
      end else if (sel == ccr_pkg::SEL_CONTROL) begin
        ctl_stage_r <= cbyte_i;
      end else if (sel == ccr_pkg::SEL_DIAG) begin
        diag_stage_r <= cbyte_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register update at the frame pulse
  // ----------------------------------------------------------------

  // Control register: tie default, then shortcut, then plain write
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctl_r <= ccr_pkg::CTL_RESET;
      default_r <= 1'b0;
    end else if (frame_pulse_i) begin
      if (tie_default) begin
        ctl_r <= default_ctl(tied_level); // RULE_13 RULE_14
        default_r <= 1'b1;
      end else if (dflt_pend_r) begin
        ctl_r <= default_ctl(dflt_high_r); // RULE_11 RULE_12
        default_r <= 1'b1;
      end else if (ctl_pend_r) begin
        ctl_r <= ctl_stage_r;
        default_r <= 1'b0;
      end
    end
  end

  // Diagnostics: default value on any default load, else loaded when written, else cleared unless retained
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      diag_r <= ccr_pkg::DIAG_CLEARED;
    end else if (frame_pulse_i) begin
      if (tie_default || dflt_pend_r) begin
        diag_r <= ccr_pkg::DIAG_DEFAULT; // RULE_11 RULE_12
      end else if (diag_pend_r) begin
        diag_r <= diag_stage_r; // RULE_03
      end else if (!ctl_r[ccr_pkg::CTL_RETAIN]) begin
        diag_r <= ccr_pkg::DIAG_CLEARED; // RULE_02
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign line_rate_select_o = ctl_r[ccr_pkg::CTL_RATE]; // RULE_05
  assign diag_reset_retain_o = ctl_r[ccr_pkg::CTL_RETAIN];
  assign signalling_in_bearer_o = ctl_r[ccr_pkg::CTL_INBEARER];
  assign pulse_shaping_enable_o = ctl_r[ccr_pkg::CTL_PSHAPE];
  assign fast_converge_o = ctl_r[ccr_pkg::CTL_FAST];
  assign tx_housekeeping_bit_o = ctl_r[ccr_pkg::CTL_TX_HOUSEKEEPING_BIT];
  assign default_mode_o = default_r;

  // D bits carried: one at low rate, two at high, all eight in bearer
  assign dchan_carry_mask_o = ctl_r[ccr_pkg::CTL_INBEARER] ? ccr_pkg::DMASK_FULL : // RULE_04
    (ctl_r[ccr_pkg::CTL_RATE] ? ccr_pkg::DMASK_HIGH : ccr_pkg::DMASK_LOW);

  // Smaller shift means a larger adaptation step
  assign adapt_shift_o = ctl_r[ccr_pkg::CTL_FAST] ? ccr_pkg::ADAPT_SHIFT_FAST : // RULE_06
    ccr_pkg::ADAPT_SHIFT_NORMAL; // RULE_07

  // ----------------------------------------------------------------
  // Diagnostics outputs; bit 7 is never used
  // ----------------------------------------------------------------
  // Loop code is read bit 2 first, so bit 2 is its high digit
  assign loopback_mode_o = {diag_r[ccr_pkg::DIAG_LOOP_LO], diag_r[ccr_pkg::DIAG_LOOP_LO + 1]}; // RULE_15
  assign loop_data_o = (loopback_mode_o == ccr_pkg::CCR_LOOP_DATA); // RULE_15
  assign loop_line_o = (loopback_mode_o == ccr_pkg::CCR_LOOP_LINE); // RULE_15
  assign loop_other_o = (loopback_mode_o == ccr_pkg::CCR_LOOP_OTHER); // RULE_15
  assign forced_unframed_o = diag_r[ccr_pkg::DIAG_UNFRAMED];
  assign poly_exchange_o = diag_r[ccr_pkg::DIAG_POLY];
  assign scrambler_poly_alt_o = diag_r[ccr_pkg::DIAG_POLY]; // RULE_16
  assign descrambler_poly_alt_o = diag_r[ccr_pkg::DIAG_POLY]; // RULE_16
  assign line_out_disable_o = diag_r[ccr_pkg::DIAG_LINE_OFF]; // RULE_17

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Plain control write lands at the next frame pulse
  ctl_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_01
    (cbyte_valid_i && cbyte_i[1:0] == 2'h0 && cbyte_i[7:4] != 4'hf && !frame_pulse_i)
    ##1 (!cbyte_valid_i && !frame_pulse_i && !tie_default) [*1] ##1
    (frame_pulse_i && !tie_default && !dflt_pend_r && !cbyte_valid_i)
    |=> (ctl_r == $past(cbyte_i, 3)))
    else $error("control write not applied at frame pulse");

  // Unwritten diagnostics clear at the frame pulse when not retained
  diag_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_02
    (frame_pulse_i && !ctl_r[2] && !diag_pend_r && !dflt_pend_r && !tie_default)
    |=> (diag_r == 8'h02))
    else $error("diagnostics not cleared at frame pulse");

  // Retained diagnostics keep their value across an idle frame pulse
  diag_retain_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_02
    (frame_pulse_i && ctl_r[2] && !diag_pend_r && !dflt_pend_r && !tie_default)
    |=> $stable(diag_r))
    else $error("retained diagnostics changed");

  // D-channel mask tracks rate and in-bearer bits
  dchan_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_04
    dchan_carry_mask_o == (ctl_r[4] ? 8'hff : (ctl_r[3] ? 8'h03 : 8'h01)))
    else $error("D-channel mask wrong");

  // Adaptation shift drops when the fast-converge bit rises
  adapt_step_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_06 RULE_07
    $rose(fast_converge_o) |-> (adapt_shift_o < $past(adapt_shift_o)))
    else $error("fast converge did not speed adaptation");

  // Shortcut byte loads a default pair at the frame pulse
  default_load_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_10 RULE_11 RULE_12
    (frame_pulse_i && dflt_pend_r && !tie_default)
    |=> (diag_r == 8'h02 && ctl_r == ($past(dflt_high_r) ? 8'h08 : 8'h00) && default_mode_o))
    else $error("default mode not loaded");

  // A tied control input in dual-port operation forces its default
  tie_default_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_13 RULE_14
    (frame_pulse_i && dual_r && tied)
    |=> (ctl_r == ($past(tied_level) ? 8'h08 : 8'h00) && diag_r == 8'h02))
    else $error("tied input default not applied");

  // Exactly one loopback path at most
  loop_onehot_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_15
    $countones({loop_data_o, loop_line_o, loop_other_o}) == (diag_r[3:2] != 2'b00))
    else $error("loopback decode wrong");

  // Both polynomials swap together, and only with the exchange bit
  poly_swap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_16
    (scrambler_poly_alt_o == descrambler_poly_alt_o) && (scrambler_poly_alt_o == diag_r[5]))
    else $error("polynomial swap inconsistent");

  // Line output disable only changes at a frame pulse
  line_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_17
    !$past(frame_pulse_i) |-> $stable(line_out_disable_o))
    else $error("line disable changed between frames");

  // Any default load raises the default flag
  default_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_10 RULE_13
    (frame_pulse_i && (tie_default || dflt_pend_r)) |=> default_mode_o)
    else $error("default flag not raised");

  // A plain control write carries its rate bit to the rate output
  rate_load_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RULE_05
    (frame_pulse_i && ctl_pend_r && !dflt_pend_r && !tie_default)
    |=> (ctl_r == $past(ctl_stage_r) && line_rate_select_o == ctl_r[3] && !default_mode_o))
    else $error("line rate not loaded");

endmodule : ccr_regs
`default_nettype wire

// *** tb/ccr_ctl_model.sv ***
// Purpose: System controller model writing C-channel bytes and frame pulses.
// Assumes: Everything runs on clk_sys_i; lines change 1 ns after a rising edge.
// Notes: Idle byte lines show the inverse of the last byte, never the old value.
`timescale 1ns/1ps
`default_nettype none
module ccr_ctl_model #(
  parameter int FRAME_GAP = 6
) (
  input wire logic clk_sys_i,
  output logic [7:0] cbyte_o,
  output logic cbyte_valid_o,
  output logic frame_pulse_o
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    cbyte_o = 8'h00;
    cbyte_valid_o = 1'b0;
    frame_pulse_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // Byte and frame tasks
  // ----------------------------------------------------------------
  // One byte strobe, then the lines are inverted so nothing stale lingers
  task automatic put_byte(input logic [7:0] b);
    @(posedge clk_sys_i);
    #1;
    cbyte_o = b;
    cbyte_valid_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    cbyte_valid_o = 1'b0;
    cbyte_o = ~b;
  endtask : put_byte

  // One frame pulse, then a quiet gap so the bank settles
  task automatic frame_tick();
    @(posedge clk_sys_i);
    #1;
    frame_pulse_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    frame_pulse_o = 1'b0;
    repeat (FRAME_GAP) @(posedge clk_sys_i);
  endtask : frame_tick

  // Control then diagnostics, both rewritten every frame
  task automatic write_frame(input logic [7:0] c, input logic [7:0] d);
    put_byte(c);
    put_byte(d & 8'h7f);
    frame_tick();
  endtask : write_frame

  // Start-up: fast convergence held for the advised frame count, then dropped
  task automatic power_up(input logic rate);
    int n;
    n = rate ? 240 : 480;
    for (int i = 0; i < n; i++) begin
      write_frame({2'b01, 2'b00, rate, 3'b100}, 8'h02);
    end
    write_frame({2'b00, 2'b00, rate, 3'b100}, 8'h02);
  endtask : power_up
endmodule : ccr_ctl_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the C-channel register bank.
// Assumes: Diagnostics bytes carry bit 0 low and bit 1 high.
// Notes: Plain writes come from a row table; awkward cases follow by hand.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] ec;
    logic [7:0] ed;
    logic dm;
  } ccr_row_s;

  logic clk_sys_i, reset_i, dual_port_mode_i, control_serial_input_i, pin_run;
  logic frame_pulse_i, cbyte_valid_i;
  logic [7:0] cbyte_i, mask;
  logic rate, ret, inb, ps, fast, tx, loop_data, loop_line, loop_other;
  logic unf, poly, scr, descr, line_off, dm_o;
  logic [3:0] shift;
  logic [1:0] loop;
  int err_total = 0;
  int cmp_count = 0;
  ccr_row_s rows [9] = '{
    '{8'h0c, 8'h06, 8'h0c, 8'h06, 1'b0}, '{8'h44, 8'h0a, 8'h44, 8'h0a, 1'b0},
    '{8'h34, 8'h2e, 8'h34, 8'h2e, 1'b0}, '{8'h9c, 8'h52, 8'h9c, 8'h52, 1'b0},
    '{8'h18, 8'h62, 8'h18, 8'h62, 1'b0}, '{8'h0b, 8'h06, 8'h18, 8'h06, 1'b0},
    '{8'hfc, 8'h2e, 8'h08, 8'h02, 1'b1}, '{8'hf0, 8'h2e, 8'h00, 8'h02, 1'b1},
    '{8'h00, 8'h0a, 8'h00, 8'h0a, 1'b0}};

  // ----------------------------------------------------------------
  // Design and controller model
  // ----------------------------------------------------------------
  ccr_regs i_ccr_regs (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .frame_pulse_i(frame_pulse_i),
    .cbyte_i(cbyte_i), .cbyte_valid_i(cbyte_valid_i), .dual_port_mode_i(dual_port_mode_i),
    .control_serial_input_i(control_serial_input_i), .line_rate_select_o(rate),
    .diag_reset_retain_o(ret), .signalling_in_bearer_o(inb), .pulse_shaping_enable_o(ps),
    .fast_converge_o(fast), .tx_housekeeping_bit_o(tx), .dchan_carry_mask_o(mask),
    .adapt_shift_o(shift), .loopback_mode_o(loop), .loop_data_o(loop_data),
    .loop_line_o(loop_line), .loop_other_o(loop_other), .forced_unframed_o(unf),
    .poly_exchange_o(poly), .scrambler_poly_alt_o(scr), .descrambler_poly_alt_o(descr),
    .line_out_disable_o(line_off), .default_mode_o(dm_o));
  ccr_ctl_model i_ccr_ctl_model (.clk_sys_i(clk_sys_i), .cbyte_o(cbyte_i),
    .cbyte_valid_o(cbyte_valid_i), .frame_pulse_o(frame_pulse_i));

  // ----------------------------------------------------------------
  // Clock, serial pin activity and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // The control pin toggles every cycle, too fast to be accepted; dual-port mode low keeps the tied-input shortcut out of the way
  always @(posedge clk_sys_i) begin
    #1;
    if (pin_run) control_serial_input_i = ~control_serial_input_i;
  end

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    err_total++;
    $display("wrong value at %0t: run did not finish in time", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Expected outputs follow from the stored control and diagnostics bytes
  task automatic check_all(input logic [7:0] ec, input logic [7:0] ed, input logic edm);
    logic [7:0] em;
    em = ec[4] ? 8'hff : (ec[3] ? 8'h03 : 8'h01);
    #2;
    chk({2'b00, tx, fast, ps, inb, rate, ret}, {2'b00, ec[7:2]}, "control");
    chk(mask, em, "carry mask");
    chk({4'h0, shift}, {4'h0, ec[6] ? ccr_pkg::ADAPT_SHIFT_FAST : ccr_pkg::ADAPT_SHIFT_NORMAL},
      "adapt shift");
    chk({3'b000, line_off, poly, unf, loop}, {3'b000, ed[6:4], ed[2], ed[3]}, "diagnostics");
    chk({5'h00, loop_other, loop_line, loop_data},
      {5'h00, ed[3:2] == 2'b11, ed[3:2] == 2'b01, ed[3:2] == 2'b10}, "loop decode");
    chk({6'h00, scr, descr}, {6'h00, ed[5], ed[5]}, "poly pair");
    chk({7'h00, dm_o}, {7'h00, edm}, "default flag");
  endtask : check_all

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    dual_port_mode_i = 1'b0;
    control_serial_input_i = 1'b0;
    pin_run = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    check_all(8'h00, 8'h02, 1'b0);
    $display("test reset values done");
    // Plain writes, a refused select and both default shortcuts
    foreach (rows[i]) begin
      i_ccr_ctl_model.write_frame(rows[i].c, rows[i].d);
      check_all(rows[i].ec, rows[i].ed, rows[i].dm);
    end
    $display("test row table done");
    // Diagnostics cleared at an empty frame unless retained
    i_ccr_ctl_model.write_frame(8'h00, 8'h42);
    i_ccr_ctl_model.frame_tick();
    check_all(8'h00, 8'h02, 1'b0);
    i_ccr_ctl_model.write_frame(8'h04, 8'h42);
    i_ccr_ctl_model.frame_tick();
    check_all(8'h04, 8'h42, 1'b0);
    // Control byte alone in a frame; retained diagnostics stay
    i_ccr_ctl_model.put_byte(8'h0c);
    i_ccr_ctl_model.frame_tick();
    check_all(8'h0c, 8'h42, 1'b0);
    $display("test diagnostics retain done");
    // Control pin tied high, then low, in dual-port operation
    pin_run = 1'b0;
    @(posedge clk_sys_i);
    #1;
    control_serial_input_i = 1'b1;
    dual_port_mode_i = 1'b1;
    repeat (6) i_ccr_ctl_model.write_frame(8'h44, 8'h06);
    check_all(8'h08, 8'h02, 1'b1);
    @(posedge clk_sys_i);
    #1;
    control_serial_input_i = 1'b0;
    repeat (6) i_ccr_ctl_model.write_frame(8'h4c, 8'h06);
    check_all(8'h00, 8'h02, 1'b1);
    @(posedge clk_sys_i);
    #1;
    dual_port_mode_i = 1'b0;
    pin_run = 1'b1;
    repeat (2) i_ccr_ctl_model.write_frame(8'h04, 8'h02);
    check_all(8'h04, 8'h02, 1'b0);
    $display("test tied input done");
    // Start-up convergence sequences at both rates
    i_ccr_ctl_model.power_up(1'b0);
    check_all(8'h04, 8'h02, 1'b0);
    i_ccr_ctl_model.power_up(1'b1);
    check_all(8'h0c, 8'h02, 1'b0);
    $display("test start-up convergence done");
    // Reset in mid-run returns every output to its reset value
    i_ccr_ctl_model.write_frame(8'hbc, 8'h6e);
    check_all(8'hbc, 8'h6e, 1'b0);
    @(posedge clk_sys_i);
    #1;
    reset_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    check_all(8'h00, 8'h02, 1'b0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
